// file: hdl/dulc_uart_line_config.sv
// Line and transmit-mode configuration for the daisy-chain UART, with a
// simple character transmitter and receive store gate driven by it.
// Assumes a byte register port and synchronous inputs on one clock.
//
// What this block does
// - Unbalanced receive bit: zero line difference reads one; transmit unchanged.
// - Rate codes 000/001 500k, 010 1M, 011 2M, 100 4M; reset 011.
// - Reserved rate codes run the UART at 500kbps.
// - Receive raw: no Manchester decode, one byte per character.
// - Transmit raw: no Manchester encode, one character per byte.
// - Continuous lead-in sends preambles nonstop, beaten only by hold.
// - Message send needs room in receive buffer or lifted limit; resets on.
// - Parity invert makes transmitted parity odd, else even.
// - Hold finishes the current byte, idles, keeps busy and quiet flags.
// - Omit end character sends messages with no stop character.
// - Omit lead-in sends messages with no preamble, extending the frame.
// - Lead-in-less data after a closed frame is not stored on receive.
// - Lifted limit allows 255-byte messages and ignores a full buffer.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module dulc_uart_line_config (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire logic [7:0] msg_data,
    input wire logic msg_send_go,
    input wire logic rx_buffer_full_flag,
    input wire logic rx_pos_input,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_char_is_lead_in,
    output logic rx_store_valid,
    output logic [7:0] rx_store_data,
    output logic tx_line,
    output logic rx_bit,
    output logic tx_busy,
    output logic tx_quiet,
    output logic [7:0] tx_bit_cycles,
    output logic tx_length_limit_lift
);

    // All module state in one struct
    typedef struct packed {
        dulc_pkg::dulc_cfg_t cfg;
        dulc_pkg::dulc_tx_state_t tx_state;
        logic [7:0] rdata;
        logic [7:0] baud_cnt;
        logic [3:0] bit_idx;
        logic [10:0] shift;
        logic shifting;
        logic half_sel;
        logic [7:0] cur_byte;
        logic [7:0] msg_count;
        logic frame_open;
        logic rx_half_pend;
        logic [3:0] rx_half;
        logic store_valid;
        logic [7:0] store_data;
        logic busy;
        logic quiet;
        logic line;
    } dulc_state_t;

    dulc_state_t state_reg, state_next;
    logic fifo_valid, fifo_ready;
    logic [7:0] fifo_data;
    logic [4:0] fifo_level;
    logic [7:0] div_sel;
    logic baud_tick;
    logic send_allowed;
    logic [7:0] msg_limit;

    // ==========
    // Functions
    // Rate decode; reserved codes fall back to the slowest rate
    function automatic logic [7:0] rate_div(input logic [2:0] code);
        unique case (code)
            dulc_pkg::RATE_500K_A, dulc_pkg::RATE_500K_B: rate_div = dulc_pkg::DIV_500K;
            dulc_pkg::RATE_1M: rate_div = dulc_pkg::DIV_1M;
            dulc_pkg::RATE_2M: rate_div = dulc_pkg::DIV_2M;
            dulc_pkg::RATE_4M: rate_div = dulc_pkg::DIV_4M;
            default: rate_div = dulc_pkg::DIV_500K;
        endcase
    endfunction : rate_div

    // Character frame: start 0, eight data bits, parity, stop 1
    function automatic logic [10:0] make_char(input logic [7:0] d, input logic odd);
        logic par;
        par = (^d) ^ odd;
        make_char = {1'b1, par, d, 1'b0};
    endfunction : make_char

    // Manchester half: nibble bits each become a 10/01 pair
    function automatic logic [7:0] manch(input logic [3:0] n);
        manch = '0;
        for (int i = 0; i < 4; i++) begin
            manch[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
        end
    endfunction : manch

    // Recover a nibble from a Manchester character
    function automatic logic [3:0] unmanch(input logic [7:0] m);
        unmanch = '0;
        for (int i = 0; i < 4; i++) begin
            unmanch[i] = m[2*i];
        end
    endfunction : unmanch

    // ==========
    // Message queue; its ready stalls the host side
    dulc_fifo #(
        .WIDTH(8),
        .DEPTH(dulc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(msg_valid),
        .in_ready(msg_ready),
        .in_data(msg_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data),
        .level(fifo_level)
    );

    // ==========
    // Derived controls
    assign div_sel = rate_div(state_reg.cfg.rate_code);
    assign baud_tick = (state_reg.baud_cnt == 8'h01);
    assign send_allowed = state_reg.cfg.msg_send && (!rx_buffer_full_flag
        || state_reg.cfg.limit_lift);
    assign msg_limit = state_reg.cfg.limit_lift ? dulc_pkg::MSG_LIMIT_LIFTED
        : dulc_pkg::MSG_LIMIT_NORMAL;
    // A byte is taken from the queue only at a data load point
    assign fifo_ready = (state_reg.tx_state == dulc_pkg::TX_DATA) && !state_reg.shifting
        && !state_reg.half_sel && !state_reg.cfg.hold && !state_reg.cfg.lead_in_cont
        && (state_reg.msg_count != msg_limit);

    // ==========
    // Outputs straight from registers; bit cycles decoded from the rate code
    assign reg_rdata = state_reg.rdata;
    assign tx_line = state_reg.line;
    assign tx_busy = state_reg.busy;
    assign tx_quiet = state_reg.quiet;
    assign tx_bit_cycles = div_sel;
    assign tx_length_limit_lift = state_reg.cfg.limit_lift;
    assign rx_store_valid = state_reg.store_valid;
    assign rx_store_data = state_reg.store_data;
    // Unbalanced mode inverts the sense so a zero difference reads one
    assign rx_bit = rx_pos_input ^ state_reg.cfg.rx_unbalanced;

    // ==========
    // Next-state logic
    always_comb begin
        logic [7:0] wd;
        logic start;
        logic [7:0] chr;
        wd = reg_wdata;
        start = 1'b0;
        chr = '0;
        state_next = state_reg;
        state_next.store_valid = 1'b0;

        // Register writes; low line bits are not stored
        if (reg_write) begin
            unique case (reg_addr)
                dulc_pkg::LINE_CONFIG_ADDR: begin
                    state_next.cfg.rx_unbalanced = wd[dulc_pkg::LC_RX_UNBALANCED_BIT];
                    state_next.cfg.rate_code = wd[dulc_pkg::LC_RATE_HI:dulc_pkg::LC_RATE_LO];
                end
                dulc_pkg::TX_MODE_CONFIG_ADDR: begin
                    state_next.cfg.rx_raw = wd[dulc_pkg::TM_RX_RAW_BIT];
                    state_next.cfg.tx_raw = wd[dulc_pkg::TM_TX_RAW_BIT];
                    state_next.cfg.lead_in_cont = wd[dulc_pkg::TM_LEAD_IN_CONT_BIT];
                    state_next.cfg.msg_send = wd[dulc_pkg::TM_MSG_SEND_BIT];
                    state_next.cfg.parity_invert = wd[dulc_pkg::TM_PARITY_INV_BIT];
                    state_next.cfg.hold = wd[dulc_pkg::TM_HOLD_BIT];
                    state_next.cfg.omit_end_char = wd[dulc_pkg::TM_OMIT_END_BIT];
                    state_next.cfg.omit_lead_in = wd[dulc_pkg::TM_OMIT_LEAD_BIT];
                end
                dulc_pkg::TX_LIMIT_CONFIG_ADDR: begin
                    state_next.cfg.limit_lift = wd[dulc_pkg::TL_LIMIT_LIFT_BIT];
                end
                default: ;
            endcase
        end

        // Register reads, data in the next cycle only
        state_next.rdata = '0;
        if (reg_read) begin
            unique case (reg_addr)
                dulc_pkg::LINE_CONFIG_ADDR: state_next.rdata = {state_reg.cfg.rx_unbalanced,
                    state_reg.cfg.rate_code, 4'h0};
                dulc_pkg::TX_MODE_CONFIG_ADDR: state_next.rdata = {state_reg.cfg.rx_raw,
                    state_reg.cfg.tx_raw, state_reg.cfg.lead_in_cont, state_reg.cfg.msg_send,
                    state_reg.cfg.parity_invert, state_reg.cfg.hold,
                    state_reg.cfg.omit_end_char, state_reg.cfg.omit_lead_in};
                dulc_pkg::TX_LIMIT_CONFIG_ADDR: state_next.rdata = {2'h0,
                    state_reg.cfg.limit_lift, 5'h00};
                dulc_pkg::LINK_STATUS_ADDR: state_next.rdata = {state_reg.busy,
                    state_reg.quiet, state_reg.frame_open, fifo_level};
                default: state_next.rdata = '0;
            endcase
        end

        // Bit timer; restarts from the divider on every tick
        if (state_reg.shifting) begin
            state_next.baud_cnt = baud_tick ? div_sel : state_reg.baud_cnt - 8'h01;
            if (baud_tick) begin
                state_next.line = state_reg.shift[0];
                state_next.shift = {1'b1, state_reg.shift[10:1]};
                state_next.bit_idx = state_reg.bit_idx + 4'h1;
                if (state_reg.bit_idx == 4'hA) begin
                    state_next.shifting = 1'b0; // Current character done
                end
            end
        end else begin
            state_next.line = 1'b1;
        end

        // Transmit sequencer; acts only between characters
        if (!state_reg.shifting) begin
            if (state_reg.cfg.hold && !state_reg.half_sel) begin
                // Idle once both halves of the byte are out; busy, quiet kept
                state_next.line = 1'b1;
            end else if (state_reg.cfg.lead_in_cont) begin
                state_next.tx_state = dulc_pkg::TX_CONT;
                chr = dulc_pkg::LEAD_IN_CHAR;
                start = 1'b1;
                state_next.busy = 1'b1;
                state_next.quiet = 1'b0;
            end else begin
                unique case (state_reg.tx_state)
                    dulc_pkg::TX_IDLE, dulc_pkg::TX_CONT: begin
                        state_next.busy = 1'b0;
                        state_next.quiet = 1'b1;
                        state_next.tx_state = dulc_pkg::TX_IDLE;
                        if (msg_send_go && send_allowed && fifo_valid) begin
                            state_next.busy = 1'b1;
                            state_next.quiet = 1'b0;
                            state_next.msg_count = '0;
                            if (state_reg.cfg.omit_lead_in) begin
                                state_next.tx_state = dulc_pkg::TX_DATA;
                            end else begin
                                chr = dulc_pkg::LEAD_IN_CHAR;
                                start = 1'b1;
                                state_next.frame_open = 1'b1;
                                state_next.tx_state = dulc_pkg::TX_DATA;
                            end
                        end
                    end
                    dulc_pkg::TX_DATA: begin
                        if (state_reg.half_sel) begin
                            chr = manch(state_reg.cur_byte[7:4]);
                            start = 1'b1;
                            state_next.half_sel = 1'b0;
                        end else if (fifo_valid && fifo_ready) begin
                            state_next.msg_count = state_reg.msg_count + 8'h01;
                            state_next.cur_byte = fifo_data;
                            start = 1'b1;
                            if (state_reg.cfg.tx_raw) begin
                                chr = fifo_data;
                            end else begin
                                chr = manch(fifo_data[3:0]);
                                state_next.half_sel = 1'b1;
                            end
                        end else begin
                            state_next.tx_state = dulc_pkg::TX_END;
                        end
                    end
                    dulc_pkg::TX_END: begin
                        state_next.tx_state = dulc_pkg::TX_IDLE;
                        if (!state_reg.cfg.omit_end_char) begin
                            chr = dulc_pkg::END_CHAR;
                            start = 1'b1;
                            state_next.frame_open = 1'b0;
                        end
                    end
                    default: state_next.tx_state = dulc_pkg::TX_IDLE;
                endcase
            end
        end

        if (start) begin
            state_next.shift = make_char(chr, state_reg.cfg.parity_invert);
            state_next.shifting = 1'b1;
            state_next.bit_idx = '0;
            state_next.baud_cnt = div_sel;
        end

        // Receive store; unframed characters are dropped
        if (rx_char_valid) begin
            if (rx_char_is_lead_in) begin
                state_next.frame_open = 1'b1;
                state_next.rx_half_pend = 1'b0;
            end else if (rx_char == dulc_pkg::END_CHAR) begin
                state_next.frame_open = 1'b0;
            end else if (state_reg.frame_open) begin
                if (state_reg.cfg.rx_raw) begin
                    state_next.store_valid = 1'b1;
                    state_next.store_data = rx_char;
                end else if (state_reg.rx_half_pend) begin
                    state_next.store_valid = 1'b1;
                    state_next.store_data = {unmanch(rx_char), state_reg.rx_half};
                    state_next.rx_half_pend = 1'b0;
                end else begin
                    state_next.rx_half = unmanch(rx_char);
                    state_next.rx_half_pend = 1'b1;
                end
            end
        end
    end

    // ==========
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.cfg.rate_code <= dulc_pkg::LINE_CONFIG_RESET[6:4];
            state_reg.cfg.msg_send <= dulc_pkg::TX_MODE_CONFIG_RESET[4];
            state_reg.tx_state <= dulc_pkg::TX_IDLE;
            state_reg.line <= 1'b1;
            state_reg.quiet <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : dulc_uart_line_config

// file: hdl/dulc_pkg.sv
// Package for the daisy-chain UART line and transmit-mode configuration block.
// Assumes a single 50 MHz clock and a byte-wide register port.
package dulc_pkg;

    // ==========
    // Register map
    localparam logic [7:0] LINE_CONFIG_ADDR = 8'h62;
    localparam logic [7:0] TX_MODE_CONFIG_ADDR = 8'h64;
    localparam logic [7:0] TX_LIMIT_CONFIG_ADDR = 8'h66;
    localparam logic [7:0] LINK_STATUS_ADDR = 8'h68;

    // ==========
    // Field positions
    localparam int LC_RX_UNBALANCED_BIT = 7;
    localparam int LC_RATE_HI = 6;
    localparam int LC_RATE_LO = 4;
    localparam int TM_RX_RAW_BIT = 7;
    localparam int TM_TX_RAW_BIT = 6;
    localparam int TM_LEAD_IN_CONT_BIT = 5;
    localparam int TM_MSG_SEND_BIT = 4;
    localparam int TM_PARITY_INV_BIT = 3;
    localparam int TM_HOLD_BIT = 2;
    localparam int TM_OMIT_END_BIT = 1;
    localparam int TM_OMIT_LEAD_BIT = 0;
    localparam int TL_LIMIT_LIFT_BIT = 5;

    // ==========
    // Reset values
    localparam logic [7:0] LINE_CONFIG_RESET = 8'h30;
    localparam logic [7:0] TX_MODE_CONFIG_RESET = 8'h10;

    // ==========
    // Rate codes and cycles per bit at 50 MHz
    localparam int CLK_HZ = 50000000;
    localparam logic [2:0] RATE_500K_A = 3'h0;
    localparam logic [2:0] RATE_500K_B = 3'h1;
    localparam logic [2:0] RATE_1M = 3'h2;
    localparam logic [2:0] RATE_2M = 3'h3;
    localparam logic [2:0] RATE_4M = 3'h4;
    localparam int BPS_500K = 500000;
    localparam int BPS_1M = 1000000;
    localparam int BPS_2M = 2000000;
    localparam int BPS_4M = 4000000;
    localparam logic [7:0] DIV_500K = 8'(CLK_HZ / BPS_500K);
    localparam logic [7:0] DIV_1M = 8'(CLK_HZ / BPS_1M);
    localparam logic [7:0] DIV_2M = 8'(CLK_HZ / BPS_2M);
    localparam logic [7:0] DIV_4M = 8'(CLK_HZ / BPS_4M);

    // ==========
    // Message limits and line characters
    localparam logic [7:0] MSG_LIMIT_NORMAL = 8'h56;
    localparam logic [7:0] MSG_LIMIT_LIFTED = 8'hFF;
    localparam logic [7:0] LEAD_IN_CHAR = 8'h15;
    localparam logic [7:0] END_CHAR = 8'h54;
    localparam int FIFO_DEPTH = 16;

    // Configuration carried to the transmit and receive paths
    typedef struct packed {
        logic rx_unbalanced;
        logic [2:0] rate_code;
        logic rx_raw;
        logic tx_raw;
        logic lead_in_cont;
        logic msg_send;
        logic parity_invert;
        logic hold;
        logic omit_end_char;
        logic omit_lead_in;
        logic limit_lift;
    } dulc_cfg_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_LEAD = 3'h1,
        TX_DATA = 3'h2,
        TX_END = 3'h3,
        TX_CONT = 3'h4
    } dulc_tx_state_t;

endpackage : dulc_pkg

// file: hdl/dulc_fifo.sv
// Synchronous FIFO holding the queued message bytes.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ns
module dulc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } dulc_fifo_state_t;

    dulc_fifo_state_t state_reg, state_next;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic push, pop, mem_has;

    // ==========
    // Handshakes
    assign mem_has = (state_reg.count != '0);
    assign in_ready = (state_reg.count != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = mem_has && (!state_reg.out_valid || out_ready);
    assign out_valid = state_reg.out_valid;
    assign out_data = state_reg.out_data;
    assign level = state_reg.count + (AW+1)'(state_reg.out_valid);

    // ==========
    // Next state; output stage refills from memory
    always_comb begin
        state_next = state_reg;
        if (state_reg.out_valid && out_ready) begin
            state_next.out_valid = 1'b0;
        end
        if (pop) begin
            state_next.out_valid = 1'b1;
            state_next.out_data = mem_reg[state_reg.rd_ptr];
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        if (push) begin
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
        if (push) begin
            mem_reg[state_reg.wr_ptr] <= in_data;
        end
    end

endmodule : dulc_fifo

// file: verification/dulc_chain_model.sv
// Chain model: decodes each character seen on tx_line.
// Assumes start, 8 data LSB first, parity, stop; tx_bit_cycles a bit.
`timescale 1ns/1ns
module dulc_chain_model (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic [7:0] tx_bit_cycles,
    output logic [7:0] n_chars,
    output logic [7:0] last_char,
    output logic last_parity
);
    // ==========
    // Receiver, sampling mid-bit to dodge edge jitter
    initial begin
        n_chars = 8'h00;
        last_char = 8'h00;
        last_parity = 1'b0;
        forever begin
            @(negedge tx_line);
            repeat (tx_bit_cycles / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (tx_bit_cycles) @(posedge clk);
                if (i < 8)
                    last_char[i] = tx_line;
                else
                    last_parity = tx_line;
            end
            repeat (tx_bit_cycles) @(posedge clk);
            n_chars = n_chars + 8'h01;
        end
    end
endmodule : dulc_chain_model

// file: verification/dulc_monitor.sv
// Checker on the ports of the line configuration block.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ns
module dulc_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_pos_input,
    input wire logic rx_bit,
    input wire logic rx_char_valid,
    input wire logic rx_store_valid,
    input wire logic tx_line,
    input wire logic tx_busy,
    input wire logic [7:0] tx_bit_cycles,
    input wire logic tx_length_limit_lift
);
    logic [3:0] lc_reg;
    logic [7:0] tm_reg;
    logic rd_lc, rd_tm, rd_bad, wr_lift;
    // ==========
    // Shadow fields, updated at the design's write edge
    always_ff @(posedge clk) begin
        if (reset) begin
            lc_reg <= 4'h3;
            tm_reg <= 8'h10;
        end else if (reg_write && reg_addr == 8'h62) begin
            lc_reg <= reg_wdata[7:4];
        end else if (reg_write && reg_addr == 8'h64) begin
            tm_reg <= reg_wdata;
        end
    end
    assign rd_lc = reg_read && reg_addr == 8'h62;
    assign rd_tm = reg_read && reg_addr == 8'h64;
    assign rd_bad = reg_read && !(reg_addr inside {8'h62, 8'h64, 8'h66, 8'h68});
    assign wr_lift = reg_write && reg_addr == 8'h66 && reg_wdata[5];
    // Reserved codes fall back to the slowest rate
    function automatic logic [7:0] cyc(input logic [2:0] r);
        case (r)
            3'h2: return 8'h32;
            3'h3: return 8'h19;
            3'h4: return 8'h0C;
            default: return 8'h64;
        endcase
    endfunction : cyc
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_RX_LEVEL: assert property (rx_bit == (rx_pos_input ^ lc_reg[3]))
        else $error("rx_bit wrong");
    AST_BIT_CYCLES: assert property (tx_bit_cycles == cyc(lc_reg[2:0]))
        else $error("bit cycles wrong");
    AST_LC_READ: assert property ($past(rd_lc) |-> reg_rdata[3:0] == 4'h0)
        else $error("line config low bits not zero");
    AST_TM_READ: assert property ($past(rd_tm) |-> reg_rdata == $past(tm_reg))
        else $error("mode register readback wrong");
    AST_UNMAPPED: assert property ($past(rd_bad) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_AFTER_RESET: assert property ($fell(reset) |-> tx_line && !tx_busy)
        else $error("busy after reset");
    AST_STORE_CAUSE: assert property (rx_store_valid |-> $past(rx_char_valid))
        else $error("store without character");
    AST_LIFT_CAUSE: assert property ($rose(tx_length_limit_lift) |->
        $past(wr_lift) || $past(wr_lift, 2))
        else $error("lift without write");
    cover property (rx_store_valid);
    cover property ($rose(tx_busy));
    cover property ($rose(tx_length_limit_lift));
endmodule : dulc_monitor
bind dulc_uart_line_config dulc_monitor i_mon (.*);

// file: verification/dulc_uart_line_config_test.sv
// Self-checking bench for the line configuration block.
// Assumes the chain model decodes every character on tx_line.
`timescale 1ns/1ns
module dulc_uart_line_config_test;
    typedef struct packed {logic [7:0] a, d, r, c;} dulc_row_t;
    logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, msg_valid = 1'b0;
    logic msg_send_go = 1'b0, rx_buffer_full_flag = 1'b0, rx_pos_input = 1'b1;
    logic rx_char_valid = 1'b0, rx_char_is_lead_in = 1'b0, msg_ready, rx_store_valid;
    logic tx_line, rx_bit, tx_busy, tx_quiet, tx_length_limit_lift, last_parity;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, msg_data = 8'h00, rx_char = 8'h00;
    logic [7:0] reg_rdata, rx_store_data, tx_bit_cycles, n_chars, last_char, rd_val, c0;
    logic [7:0] last_store = 8'h00;
    int miscompares = 0, n_tests = 0, n_store = 0;
    // Address, write, readback, cycles per bit
    dulc_row_t rows[10] = '{{8'h62, 8'h00, 8'h00, 8'h64}, {8'h62, 8'h10, 8'h10, 8'h64},
        {8'h62, 8'h20, 8'h20, 8'h32}, {8'h62, 8'h3F, 8'h30, 8'h19},
        {8'h62, 8'hD0, 8'hD0, 8'h64}, {8'h62, 8'hE0, 8'hE0, 8'h64},
        {8'h62, 8'hF0, 8'hF0, 8'h64}, {8'h50, 8'hAA, 8'h00, 8'h64},
        {8'h64, 8'h8F, 8'h8F, 8'h64}, {8'h62, 8'hC0, 8'hC0, 8'h0C}};
    always #10 clk = ~clk;
    dulc_uart_line_config i_dut (.*);
    dulc_chain_model i_chain (.*);
    // ==========
    // Store monitor
    always @(posedge clk) begin
        if (rx_store_valid === 1'b1) begin
            n_store <= n_store + 1;
            last_store <= rx_store_data;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Gap cycle after each strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic rxc(input logic l, input logic [7:0] c);
        rx_char_is_lead_in <= l;
        rx_char <= c;
        rx_char_valid <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : rxc
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic wait_chars(input logic [7:0] n);
        int k;
        for (k = 0; k < 4000 && n_chars < n; k++) @(posedge clk);
        if (k == 4000) begin
            miscompares++;
            $display("wrong value char count expected %h seen %h", n, n_chars);
            finish_test();
        end
    endtask : wait_chars
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h62);
        chk("line_config", 8'h30, rd_val);
        rd(8'h64);
        chk("transmit_mode_config", 8'h10, rd_val);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("readback", rows[i].r, rd_val);
            chk("bit cycles", rows[i].c, tx_bit_cycles);
        end
        rx_pos_input <= 1'b0;
        @(posedge clk);
        #1 chk("rx_bit", 8'h01, {7'h00, rx_bit});
        $display("register table done");
        wr(8'h64, 8'h80);
        rxc(1'b0, 8'h5A);
        chk("unframed stores", 8'h00, n_store[7:0]);
        rxc(1'b1, 8'h15);
        rxc(1'b0, 8'h3C);
        chk("raw stores", 8'h01, n_store[7:0]);
        chk("raw byte", 8'h3C, last_store);
        wr(8'h64, 8'h00);
        rxc(1'b0, 8'h66);
        rxc(1'b0, 8'h99);
        chk("manchester byte", 8'h5A, last_store);
        $display("receive test done");
        rx_buffer_full_flag <= 1'b1;
        wr(8'h64, 8'h5B);
        msg_data <= 8'hA5;
        msg_valid <= 1'b1;
        @(posedge clk);
        msg_valid <= 1'b0;
        msg_send_go <= 1'b1;
        repeat (400) @(posedge clk);
        chk("withheld when full", 8'h00, n_chars);
        wr(8'h66, 8'h20);
        wait_chars(8'h01);
        repeat (200) @(posedge clk);
        chk("chars sent", 8'h01, n_chars);
        chk("raw byte", 8'hA5, last_char);
        chk("odd parity", 8'h01, {7'h00, last_parity});
        msg_send_go <= 1'b0;
        $display("message test done");
        wr(8'h64, 8'h24);
        repeat (400) @(posedge clk);
        chk("held lead-in", 8'h01, n_chars);
        wr(8'h64, 8'h20);
        wait_chars(8'h03);
        chk("lead-in char", 8'h15, last_char);
        chk("even parity", 8'h01, {7'h00, last_parity});
        wr(8'h64, 8'h24);
        repeat (300) @(posedge clk);
        c0 = n_chars;
        repeat (400) @(posedge clk);
        chk("hold stops", c0, n_chars);
        chk("busy quiet", 8'h02, {6'h00, tx_busy, tx_quiet});
        $display("lead-in test done");
        finish_test();
    end
endmodule : dulc_uart_line_config_test
